// ---- pcsia_pkg.sv ----
// Package for the program counter, return stack and indirect addressing block.
// Assumes a single core clock domain; shared by the top and the stack memory.
package pcsia_pkg;
  localparam int PCSIA_PC_W = 13;
  localparam int PCSIA_LOW_W = 8;
  localparam int PCSIA_HIGH_W = 5;
  localparam int PCSIA_STACK_DEPTH = 8;
  localparam int PCSIA_SP_W = 3;
  localparam int PCSIA_DADDR_W = 9;
  localparam int PCSIA_JUMP_W = 11;
  localparam logic [7:0] PCSIA_INDIRECT_PORT_ADDR = 8'h00;
  localparam logic [7:0] PCSIA_INDIRECT_READ_VALUE = 8'h00;
  localparam logic [12:0] PCSIA_PC_RESET = 13'h0000;
  localparam logic [12:0] PCSIA_INT_VECTOR = 13'h0004;
  localparam logic [2:0] PCSIA_SP_RESET = 3'h0;

  // Operation requested by the instruction decoder for one instruction cycle.
  typedef enum logic [2:0] {
    PCSIA_OP_STEP = 3'h0,
    PCSIA_OP_JUMP = 3'h1,
    PCSIA_OP_CALL = 3'h2,
    PCSIA_OP_RET = 3'h3,
    PCSIA_OP_IRQ = 3'h4,
    PCSIA_OP_WRLOW = 3'h5,
    PCSIA_OP_HOLD = 3'h6
  } pcsia_op_t;

  // One request from the decoder.
  typedef struct packed {
    pcsia_op_t op;
    logic [10:0] target;
    logic [7:0] low_data;
  } pcsia_req_t;

  // Indirect access request: data access through a file address.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] file_addr;
    logic [7:0] wdata;
  } pcsia_dreq_t;

  // Data memory access that results.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pcsia_dacc_t;
endpackage

// ---- pcsia_stack_mem.sv ----
// Return stack storage: depth by width words, one write port, registered read.
// Assumes the caller owns the pointer; no overflow tracking here.
`timescale 1ns/1ps
module pcsia_stack_mem
  import pcsia_pkg::*;
#(
  parameter int DEPTH = PCSIA_STACK_DEPTH,
  parameter int WIDTH = PCSIA_PC_W,
  parameter int AW = PCSIA_SP_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- pcsia_core.sv ----
// Program counter, circular return stack and indirect data address former.
// Assumes the decoder issues one request per clock and keeps it legal.
//
// Notes on behaviour
// - Program counter is thirteen bits wide.
// - Low eight bits of the counter read and write like a register.
// - Upper five counter bits load from the high latch on a low byte write.
// - Writing the low byte copies latch bits four to zero upward.
// - Call and jump take top two bits from latch bits four and three.
// - Every reset clears the whole counter.
// - Eight entry, thirteen bit return stack outside program and data space.
// - Stack pointer is internal and invisible to software.
// - Call pushes the counter plus one; accepted interrupt pushes the current counter.
// - Return, literal return and interrupt exit pop into the counter.
// - Push and pop never change the high latch.
// - Stack wraps; ninth push overwrites the first.
// - No overflow or underflow indication exists.
// - Indirect port has no storage; it reaches the pointed location.
// - Reading the port through itself returns zero.
// - Writing the port through itself stores nothing.
// - Indirect address joins bank bit and eight-bit pointer.
`timescale 1ns/1ps
module pcsia_core
  import pcsia_pkg::*;
#(
  parameter logic [12:0] INT_VECTOR = PCSIA_INT_VECTOR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcsia_req_t req,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] file_select_pointer,
  input wire logic indirect_bank_bit,
  input wire pcsia_dreq_t dreq,
  input wire logic [7:0] mem_rdata,
  output logic [12:0] pc,
  output logic [7:0] pc_low_byte_reg,
  output pcsia_dacc_t dacc,
  output logic [7:0] dreq_rdata
);
  logic [PCSIA_SP_W-1:0] sp;
  logic [PCSIA_SP_W-1:0] next_sp;
  logic [12:0] next_pc;
  logic [12:0] top_word;
  logic [12:0] push_word;
  logic push;
  logic pop;
  logic [PCSIA_SP_W-1:0] rd_ptr;
  logic pc_ready;
  logic [12:0] pc_plus;
  logic self_ref;
  logic [8:0] ind_addr;
  logic self_rd;

  assign push = (req.op == PCSIA_OP_CALL) || (req.op == PCSIA_OP_IRQ);
  assign pop = (req.op == PCSIA_OP_RET);
  assign pc_plus = pc + 13'h0001;
  // The return address is the instruction after the call; an interrupt resumes at pc.
  assign push_word = (req.op == PCSIA_OP_CALL) ? pc_plus : pc;

  // Pointer is a plain 3-bit counter; wrapping is natural modulo eight.
  always_comb begin
    next_sp = sp;
    if (push) begin
      next_sp = sp + 3'h1;
    end else if (pop) begin
      next_sp = sp - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= PCSIA_SP_RESET;
    end else begin
      sp <= next_sp;
    end
  end

  // Read port always tracks the current top so that a pop finds it registered.
  assign rd_ptr = next_sp - 3'h1;

  pcsia_stack_mem #(
    .DEPTH(PCSIA_STACK_DEPTH),
    .WIDTH(PCSIA_PC_W),
    .AW(PCSIA_SP_W)
  ) u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(push),
    .wr_addr(sp),
    .wr_data(push_word),
    .rd_addr(rd_ptr),
    .rd_data(top_word)
  );

  // A push followed at once by a pop must see the word just written.
  logic [12:0] last_push;
  logic last_was_push;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_push <= PCSIA_PC_RESET;
      last_was_push <= 1'b0;
    end else begin
      last_push <= push_word;
      last_was_push <= push;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ready <= 1'b0;
    end else begin
      pc_ready <= 1'b1;
    end
  end

  // Next counter value. The high latch is only read here, never written.
  always_comb begin
    next_pc = pc_plus;
    unique case (req.op)
      PCSIA_OP_STEP: begin
        next_pc = pc_plus;
      end
      PCSIA_OP_JUMP, PCSIA_OP_CALL: begin
        next_pc = {pc_high_latch[4:3], req.target};
      end
      PCSIA_OP_RET: begin
        next_pc = last_was_push ? last_push : top_word;
      end
      PCSIA_OP_IRQ: begin
        next_pc = INT_VECTOR;
      end
      PCSIA_OP_WRLOW: begin
        next_pc = {pc_high_latch[4:0], req.low_data};
      end
      PCSIA_OP_HOLD: begin
        next_pc = pc;
      end
      default: begin
        next_pc = pc;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PCSIA_PC_RESET;
      pc_low_byte_reg <= 8'h00;
    end else begin
      pc <= next_pc;
      pc_low_byte_reg <= next_pc[7:0];
    end
  end

  // Indirect access: the port itself holds nothing and forwards to memory.
  assign ind_addr = {indirect_bank_bit, file_select_pointer};
  assign self_ref = (dreq.file_addr == PCSIA_INDIRECT_PORT_ADDR)
                 && (file_select_pointer == PCSIA_INDIRECT_PORT_ADDR);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacc <= '0;
      self_rd <= 1'b0;
    end else begin
      self_rd <= dreq.rd && self_ref;
      if (dreq.file_addr == PCSIA_INDIRECT_PORT_ADDR) begin
        dacc.addr <= ind_addr;
        dacc.rd <= dreq.rd && !self_ref;
        dacc.wr <= dreq.wr && !self_ref;
      end else begin
        dacc.addr <= {indirect_bank_bit, dreq.file_addr};
        dacc.rd <= dreq.rd;
        dacc.wr <= dreq.wr;
      end
      dacc.wdata <= dreq.wdata;
    end
  end

  // Read data is registered; a self-referencing read answers zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dreq_rdata <= 8'h00;
    end else begin
      dreq_rdata <= self_rd ? PCSIA_INDIRECT_READ_VALUE : mem_rdata;
    end
  end

  // Checks.
  sequence s_call_now;
    req.op == PCSIA_OP_CALL;
  endsequence

  sequence s_ret_now;
    req.op == PCSIA_OP_RET;
  endsequence

  sequence s_jump_now;
    req.op == PCSIA_OP_JUMP;
  endsequence

  sequence s_irq_now;
    req.op == PCSIA_OP_IRQ;
  endsequence

  sequence s_wrlow_now;
    req.op == PCSIA_OP_WRLOW;
  endsequence

  sequence s_step_now;
    req.op == PCSIA_OP_STEP;
  endsequence

  sequence s_hold_now;
    req.op == PCSIA_OP_HOLD;
  endsequence

  // An access that the indirect port forwards to the pointed location.
  sequence s_ind_forward;
    (dreq.rd || dreq.wr) && dreq.file_addr == PCSIA_INDIRECT_PORT_ADDR && !self_ref;
  endsequence

  a_pc_reset_zero: assert property (@(posedge clk) $rose(rst_n) |-> pc == 13'h0000)
    else $error("pc not zero after reset");

  a_low_write_load: assert property (@(posedge clk) disable iff (!rst_n)
    req.op == PCSIA_OP_WRLOW |=> pc == {$past(pc_high_latch[4:0]), $past(req.low_data)})
    else $error("low byte write load wrong");

  a_jump_upper_bits: assert property (@(posedge clk) disable iff (!rst_n)
    req.op == PCSIA_OP_JUMP |=> pc[12:11] == $past(pc_high_latch[4:3]))
    else $error("jump upper bits wrong");

  a_call_return_pair: assert property (@(posedge clk) disable iff (!rst_n)
    s_call_now ##1 s_ret_now |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return did not restore call address");

  a_irq_vector_push: assert property (@(posedge clk) disable iff (!rst_n)
    req.op == PCSIA_OP_IRQ |=> pc == INT_VECTOR && sp == $past(sp) + 3'h1)
    else $error("interrupt entry wrong");

  a_stack_wraps: assert property (@(posedge clk) disable iff (!rst_n)
    (push && sp == 3'h7) |=> sp == 3'h0)
    else $error("stack pointer did not wrap");

  a_low_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    pc_ready |-> pc_low_byte_reg == pc[7:0])
    else $error("low byte mirror mismatch");

  a_ind_addr_form: assert property (@(posedge clk) disable iff (!rst_n)
    (dreq.rd && dreq.file_addr == 8'h00 && !self_ref)
    |=> dacc.rd && dacc.addr == {$past(indirect_bank_bit), $past(file_select_pointer)})
    else $error("indirect address wrong");

  a_self_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (dreq.rd && self_ref) |=> !dacc.rd ##1 dreq_rdata == 8'h00)
    else $error("self read not zero");

  a_self_write_none: assert property (@(posedge clk) disable iff (!rst_n)
    (dreq.wr && self_ref) |=> !dacc.wr)
    else $error("self write reached memory");

  // Sequencing checks: every operation leaves the counter and pointer where expected.
  a_step_increment: assert property (@(posedge clk) disable iff (!rst_n)
    s_step_now |=> pc == $past(pc) + 13'h0001)
    else $error("step did not advance the counter");

  a_hold_keeps_pc: assert property (@(posedge clk) disable iff (!rst_n)
    s_hold_now |=> pc == $past(pc))
    else $error("hold changed the counter");

  a_low_write_byte: assert property (@(posedge clk) disable iff (!rst_n)
    s_wrlow_now |=> pc_low_byte_reg == $past(req.low_data))
    else $error("low byte register not written");

  a_low_write_upper: assert property (@(posedge clk) disable iff (!rst_n)
    s_wrlow_now |=> pc[12:8] == $past(pc_high_latch[4:0]))
    else $error("upper bits not taken from the latch");

  a_jump_low_bits: assert property (@(posedge clk) disable iff (!rst_n)
    s_jump_now |=> pc[10:0] == $past(req.target))
    else $error("jump target bits wrong");

  a_call_target: assert property (@(posedge clk) disable iff (!rst_n)
    s_call_now |=> pc == {$past(pc_high_latch[4:3]), $past(req.target)})
    else $error("call target wrong");

  a_jump_no_push: assert property (@(posedge clk) disable iff (!rst_n)
    s_jump_now |=> sp == $past(sp))
    else $error("jump moved the stack pointer");

  a_call_push_sp: assert property (@(posedge clk) disable iff (!rst_n)
    s_call_now |=> sp == $past(sp) + 3'h1)
    else $error("call did not push");

  a_pop_sp_down: assert property (@(posedge clk) disable iff (!rst_n)
    s_ret_now |=> sp == $past(sp) - 3'h1)
    else $error("return did not pop");

  a_pop_empty_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (pop && sp == 3'h0) |=> sp == 3'h7)
    else $error("pointer did not wrap on pop");

  a_irq_ret_pair: assert property (@(posedge clk) disable iff (!rst_n)
    s_irq_now ##1 s_ret_now |=> pc == $past(pc, 2))
    else $error("interrupt exit did not resume");

  a_irq_step_ret: assert property (@(posedge clk) disable iff (!rst_n)
    s_irq_now ##1 s_step_now ##1 s_ret_now |=> pc == $past(pc, 3))
    else $error("stored return word lost");

  a_sp_steady: assert property (@(posedge clk) disable iff (!rst_n)
    (!push && !pop) |=> sp == $past(sp))
    else $error("stack pointer moved without push or pop");

  a_low_reset_zero: assert property (@(posedge clk) $rose(rst_n) |-> pc_low_byte_reg == 8'h00)
    else $error("low byte not zero after reset");

  // Indirect path checks.
  a_direct_pass: assert property (@(posedge clk) disable iff (!rst_n)
    dreq.file_addr != PCSIA_INDIRECT_PORT_ADDR
    |=> dacc.rd == $past(dreq.rd) && dacc.wr == $past(dreq.wr)
        && dacc.addr == {$past(indirect_bank_bit), $past(dreq.file_addr)})
    else $error("direct access not passed through");

  a_ind_forward: assert property (@(posedge clk) disable iff (!rst_n)
    s_ind_forward |=> dacc.rd == $past(dreq.rd) && dacc.wr == $past(dreq.wr))
    else $error("indirect access not forwarded");

  a_bank_top_bit: assert property (@(posedge clk) disable iff (!rst_n)
    s_ind_forward
    |=> dacc.addr[8] == $past(indirect_bank_bit) && dacc.addr[7:0] == $past(file_select_pointer))
    else $error("bank bit or pointer misplaced");

  a_ind_write_data: assert property (@(posedge clk) disable iff (!rst_n)
    (dreq.wr && dreq.file_addr == PCSIA_INDIRECT_PORT_ADDR && !self_ref)
    |=> dacc.wr && dacc.wdata == $past(dreq.wdata))
    else $error("indirect write data wrong");

  a_ind_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    (dreq.rd && dreq.file_addr == PCSIA_INDIRECT_PORT_ADDR && !self_ref) ##1 dacc.rd
    |=> dreq_rdata == $past(mem_rdata))
    else $error("indirect read data wrong");

  a_dacc_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!dreq.rd && !dreq.wr) |=> !dacc.rd && !dacc.wr)
    else $error("memory access without request");
endmodule

// ---- pcsia_mem_model.sv ----
// Data memory model on the far side of the indirect access port.
// Assumes one access per cycle from the core; read data lasts one cycle more.
`timescale 1ns/1ps
module pcsia_mem_model
  import pcsia_pkg::*;
(
  input wire logic clk,
  input wire pcsia_dacc_t dacc,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [512];
  logic rd_q = 1'b0;
  logic [8:0] addr_q = 9'h000;
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = i[7:0] ^ 8'h3C;
    end
  end
  always @(posedge clk) begin
    rd_q <= dacc.rd;
    addr_q <= dacc.addr;
    if (dacc.wr) begin
      mem[dacc.addr] <= dacc.wdata;
    end
  end
  // Outside the valid window the data is inverted so that a late sample fails.
  assign mem_rdata = dacc.rd ? mem[dacc.addr] : (rd_q ? mem[addr_q] : ~mem[addr_q]);
endmodule

// ---- pcsia_core_test.sv ----
// Testbench for the program counter, return stack and indirect addressing core.
// Assumes the memory model answers indirect accesses; one 200 MHz clock.
`timescale 1ns/1ps
module pcsia_core_test;
  import pcsia_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pcsia_req_t req = '{PCSIA_OP_HOLD, 11'h000, 8'h00};
  logic [7:0] latch = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic bank = 1'b0;
  pcsia_dreq_t dreq = '0;
  logic [7:0] mem_rdata;
  logic [12:0] pc;
  logic [7:0] low;
  pcsia_dacc_t dacc;
  logic [7:0] rdata;
  logic [12:0] e [9];
  logic [12:0] prev;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  pcsia_core DUT (.clk(clk), .rst_n(rst_n), .req(req), .pc_high_latch(latch),
    .file_select_pointer(ptr), .indirect_bank_bit(bank), .dreq(dreq), .mem_rdata(mem_rdata),
    .pc(pc), .pc_low_byte_reg(low), .dacc(dacc), .dreq_rdata(rdata));
  pcsia_mem_model MEM (.clk(clk), .dacc(dacc), .mem_rdata(mem_rdata));
  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Applies one request at a falling edge and returns after the update lands.
  task automatic go(input pcsia_op_t op, input logic [10:0] t, input logic [7:0] d);
    req = '{op, t, d};
    @(negedge clk);
  endtask
  task automatic acc(input logic w, input logic hit, input logic [7:0] f, input logic [8:0] a,
    input logic [7:0] d);
    dreq = '{~w, w, f, d};
    @(negedge clk);
    dreq = '0;
    chk({12'h000, dacc.rd}, {12'h000, ~w & hit});
    chk({12'h000, dacc.wr}, {12'h000, w & hit});
    if (hit) chk({4'h0, dacc.addr}, {4'h0, a});
    if (hit && w) chk({5'h00, dacc.wdata}, {5'h00, d});
    @(negedge clk);
    if (!w) chk({5'h00, rdata}, {5'h00, d});
  endtask
  task automatic t_low();
    latch = 8'hFA;
    go(PCSIA_OP_WRLOW, 11'h000, 8'h55);
    chk(pc, 13'h1A55);
    chk({5'h00, low}, 13'h0055);
    go(PCSIA_OP_WRLOW, 11'h000, 8'hFF);
    go(PCSIA_OP_STEP, 11'h000, 8'h00);
    chk(pc, 13'h1B00);
    latch = 8'h1F;
    go(PCSIA_OP_WRLOW, 11'h000, 8'hFF);
    chk(pc, 13'h1FFF);
    go(PCSIA_OP_STEP, 11'h000, 8'h00);
    chk(pc, 13'h0000);
  endtask
  task automatic t_jump();
    latch = 8'h07;
    go(PCSIA_OP_JUMP, 11'h7FF, 8'h00);
    chk(pc, 13'h07FF);
    latch = 8'h18;
    go(PCSIA_OP_JUMP, 11'h123, 8'h00);
    chk(pc, 13'h1923);
  endtask
  // A computed jump adds an offset to the low byte; the table stays inside one block.
  task automatic t_table();
    latch = 8'h03;
    go(PCSIA_OP_JUMP, 11'h320, 8'h00);
    go(PCSIA_OP_WRLOW, 11'h000, 8'h20 + 8'h05);
    chk(pc, 13'h0325);
  endtask
  // Nine calls overfill the eight entries; nine returns then show the wrap.
  task automatic t_stack();
    latch = 8'h10;
    go(PCSIA_OP_JUMP, 11'h040, 8'h00);
    prev = 13'h1040;
    for (int k = 0; k < 9; k++) begin
      e[k] = prev + 13'h0001;
      go(PCSIA_OP_CALL, 11'h100 + 11'(k), 8'h00);
      prev = 13'h1100 + 13'(k);
      chk(pc, prev);
    end
    for (int k = 0; k < 9; k++) begin
      go(PCSIA_OP_RET, 11'h000, 8'h00);
      chk(pc, e[(k == 8) ? 8 : 8 - k]);
    end
  endtask
  task automatic t_irq();
    latch = 8'h00;
    go(PCSIA_OP_JUMP, 11'h055, 8'h00);
    go(PCSIA_OP_IRQ, 11'h000, 8'h00);
    chk(pc, PCSIA_INT_VECTOR);
    go(PCSIA_OP_STEP, 11'h000, 8'h00);
    go(PCSIA_OP_RET, 11'h000, 8'h00);
    chk(pc, 13'h0055);
    go(PCSIA_OP_CALL, 11'h300, 8'h00);
    go(PCSIA_OP_RET, 11'h000, 8'h00);
    chk(pc, 13'h0056);
    go(PCSIA_OP_IRQ, 11'h000, 8'h00);
    go(PCSIA_OP_RET, 11'h000, 8'h00);
    chk(pc, 13'h0056);
    go(PCSIA_OP_HOLD, 11'h000, 8'h00);
  endtask
  task automatic t_ind();
    ptr = 8'h21;
    bank = 1'b1;
    acc(1'b1, 1'b1, 8'h00, 9'h121, 8'hA5);
    acc(1'b0, 1'b1, 8'h00, 9'h121, 8'hA5);
    bank = 1'b0;
    acc(1'b0, 1'b1, 8'h00, 9'h021, 8'h1D);
    acc(1'b0, 1'b1, 8'h30, 9'h030, 8'h0C);
    ptr = 8'h00;
    acc(1'b0, 1'b0, 8'h00, 9'h000, 8'h00);
    acc(1'b1, 1'b0, 8'h00, 9'h000, 8'h77);
  endtask
  task automatic t_reset();
    go(PCSIA_OP_JUMP, 11'h2AA, 8'h00);
    chk(pc, 13'h02AA);
    rst_n = 1'b0;
    req = '{PCSIA_OP_STEP, 11'h000, 8'h00};
    @(negedge clk);
    chk(pc, 13'h0000);
    chk({5'h00, low}, 13'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    chk(pc, 13'h0001);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    chk(pc, 13'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    t_low();
    t_jump();
    t_table();
    t_stack();
    t_irq();
    t_ind();
    t_reset();
    end_of_test();
  end
endmodule
